// ==== bench/host_model.sv ====
// host side step pin: toggles at its own rate only while asked
`timescale 1ns/1ps
`default_nettype none
module host_model
(
	input wire logic run,
	output logic step
);
	// idle low between bursts, never left floating
	initial step = 1'b0;
	always #80 step = run ? ~step : 1'b0;
endmodule
`default_nettype wire

// ==== bench/stepper_sva.sv ====
// checker of bus, sleep and fault timing at the stepper block ports
`timescale 1ns/1ps
`default_nettype none
module stepper_sva
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic hw_wake_n,
	input wire logic strobe_n,
	input wire logic regulator_off,
	input wire logic [9:0] fault_in,
	input wire logic [5:0] phase_a_level,
	input wire logic outputs_enable,
	input wire logic regulators_on,
	input wire logic diag_oe
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_answer; psel && !penable |=> pready; endproperty
	a_answer: assert property (p_answer) else $error("no answer");
	property p_one; pready |=> !pready; endproperty
	a_one: assert property (p_one) else $error("pready held");
	property p_unmapped;
		psel && !penable && paddr > stepper_pkg::OFS_TABLE |=> pslverr;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("no slverr");
	property p_pin_sleep;
		(!hw_wake_n)[*6] |-> !regulators_on && !outputs_enable;
	endproperty
	a_pin_sleep: assert property (p_pin_sleep) else $error("awake");
	property p_sleep_ok; (!hw_wake_n && regulator_off)[*6] |-> !diag_oe;
	endproperty
	a_sleep_ok: assert property (p_sleep_ok) else $error("diag low");
	property p_sleep_bad; (!hw_wake_n && !regulator_off)[*6] |-> diag_oe;
	endproperty
	a_sleep_bad: assert property (p_sleep_bad) else $error("diag high");
	property p_bit_sleep;
		psel && penable && pready && pwrite && paddr == stepper_pkg::OFS_CTRL
		&& pwdata[stepper_pkg::CTRL_SLEEP] && strobe_n ##1 strobe_n[*3]
		|-> !regulators_on;
	endproperty
	a_bit_sleep: assert property (p_bit_sleep) else $error("late");
	property p_ov_off; fault_in[stepper_pkg::F_OV][*5] |-> !outputs_enable;
	endproperty
	a_ov_off: assert property (p_ov_off) else $error("bridge on");
	property p_home; (!hw_wake_n)[*8] |-> $stable(phase_a_level); endproperty
	a_home: assert property (p_home) else $error("angle moved");
endmodule
bind stepper_sequencer_sleep_fault_ctrl stepper_sva u_sva
(
	.pclk(pclk),
	.presetn(presetn),
	.psel(psel),
	.penable(penable),
	.pwrite(pwrite),
	.paddr(paddr),
	.pwdata(pwdata),
	.pready(pready),
	.pslverr(pslverr),
	.hw_wake_n(hw_wake_n),
	.strobe_n(strobe_n),
	.regulator_off(regulator_off),
	.fault_in(fault_in),
	.phase_a_level(phase_a_level),
	.outputs_enable(outputs_enable),
	.regulators_on(regulators_on),
	.diag_oe(diag_oe)
);
`default_nettype wire

// ==== bench/testbench.sv ====
// self-checking bench of the stepper sequencer block
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic dir = 1'b0;
	logic hw_wake_n = 1'b1;
	logic strobe_n = 1'b1;
	logic regulator_off = 1'b0;
	logic [9:0] fault_in = 10'h000;
	logic run = 1'b0;
	logic [31:0] prdata, r;
	logic pready, pslverr, err, step, phase_a_dir, phase_b_dir;
	logic [5:0] phase_a_level, phase_b_level, ang;
	logic outputs_enable, regulators_on, diag_out, diag_oe;
	logic [5:0] deltas [4] = '{6'h3F, 6'h10, 6'h30, 6'h02};
	int mismatches = 0;
	int compares = 0;
	int cycles = 0;
	always #10 pclk = ~pclk;
	host_model host (.run(run), .step(step));
	stepper_sequencer_sleep_fault_ctrl DUT
	(
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.step(step),
		.dir(dir),
		.hw_wake_n(hw_wake_n),
		.strobe_n(strobe_n),
		.regulator_off(regulator_off),
		.fault_in(fault_in),
		.phase_a_level(phase_a_level),
		.phase_a_dir(phase_a_dir),
		.phase_b_level(phase_b_level),
		.phase_b_dir(phase_b_dir),
		.outputs_enable(outputs_enable),
		.regulators_on(regulators_on),
		.diag_out(diag_out),
		.diag_oe(diag_oe)
	);
	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task tally_and_finish;
		if (mismatches == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// request held from setup until pready is seen high at a rising edge
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		r = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task steps(input int n);
		@(posedge pclk);
		run <= 1'b1;
		repeat (n) @(posedge step);
		@(posedge pclk);
		run <= 1'b0;
		repeat (10) @(posedge pclk);
	endtask
	task angle_is(input logic [5:0] e);
		apb(1'b0, stepper_pkg::OFS_STEP, 32'h0);
		chk(r & 32'h3F, {26'h0, e});
	endtask
	task settle;
		repeat (6) @(posedge pclk);
	endtask
	// grids are powers of two, so a mask finds the next legal angle
	function logic [5:0] next_ok(input logic [5:0] a, input logic [2:0] m);
		logic [5:0] g, o, n;
		g = (m < 2) ? 6'h10 : (m < 4) ? 6'h08 : (m == 4) ? 6'h04 : 6'h01;
		g = (m == 5) ? 6'h02 : g;
		o = (m == 1) ? 6'h08 : 6'h00;
		n = a + 6'h01;
		while (((n - o) & (g - 6'h01)) != 6'h00)
			n = n + 6'h01;
		return n;
	endfunction
	always @(posedge pclk)
	begin
		cycles++;
		if (cycles == 30000)
		begin
			mismatches++;
			tally_and_finish;
		end
	end
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial
	begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		angle_is(6'h08);
		apb(1'b0, stepper_pkg::OFS_CTRL, 32'h0);
		chk(r & 32'hFF, 32'h0C);
		apb(1'b0, 8'h10, 32'h0);
		chk({31'h0, err}, 32'h1);
		apb(1'b1, stepper_pkg::OFS_TABLE, 32'h0010_2A55);
		steps(1);
		angle_is(6'h10);
		chk({18'h0, phase_a_dir, phase_a_level, phase_b_dir, phase_b_level},
			32'h2A55);
		ang = 6'h10;
		for (int i = 3; i >= 0; i--)
		begin
			dir <= i[1];
			apb(1'b1, stepper_pkg::OFS_CTRL, {27'h0, 3'h3, i[0], 1'b0});
			ang = ang + ((i == 0) ? 6'h08 : 6'h38);
			steps(1);
			angle_is(ang);
		end
		for (int m = 0; m < 8; m++)
		begin
			apb(1'b1, stepper_pkg::OFS_CTRL, {27'h0, m[2:0], 2'h0});
			ang = next_ok(ang, m[2:0]);
			steps(1);
			angle_is(ang);
		end
		apb(1'b1, stepper_pkg::OFS_CTRL, 32'h98);
		for (int k = 0; k < 4; k++)
		begin
			apb(1'b1, stepper_pkg::OFS_STEP, {26'h0, deltas[k]});
			ang = ang + deltas[k];
			angle_is(ang);
		end
		regulator_off <= 1'b1;
		apb(1'b1, stepper_pkg::OFS_CTRL, 32'h99);
		settle;
		chk({regulators_on, outputs_enable, diag_oe}, 32'h0);
		angle_is(6'h08);
		for (int j = 1; j >= 0; j--)
		begin
			strobe_n <= 1'b0;
			settle;
			apb(1'b1, stepper_pkg::OFS_CTRL, {31'h0C, j[0]});
			strobe_n <= 1'b1;
			settle;
			chk({31'h0, regulators_on}, {31'h0, ~j[0]});
		end
		regulator_off <= 1'b0;
		fault_in <= 10'h090;
		settle;
		chk({31'h0, outputs_enable}, 32'h1);
		fault_in <= 10'h000;
		settle;
		chk({diag_out, diag_oe}, 32'h1);
		apb(1'b0, stepper_pkg::OFS_STATUS, 32'h0);
		chk(r & 32'h3FF, 32'h090);
		apb(1'b0, stepper_pkg::OFS_STATUS, 32'h0);
		chk(r & 32'h3FF, 32'h000);
		fault_in <= 10'h001;
		apb(1'b1, stepper_pkg::OFS_CTRL, 32'h58);
		settle;
		chk({outputs_enable, diag_oe}, 32'h1);
		apb(1'b1, stepper_pkg::OFS_CTRL, 32'h38);
		settle;
		chk({31'h0, diag_oe}, 32'h0);
		fault_in <= 10'h101;
		steps(8);
		chk({31'h0, diag_oe}, 32'h1);
		fault_in <= 10'h000;
		apb(1'b1, stepper_pkg::OFS_CTRL, 32'h58);
		settle;
		chk({outputs_enable, diag_oe}, 32'h2);
		apb(1'b1, stepper_pkg::OFS_CTRL, 32'h40);
		for (int s = 0; s < 2; s++)
		begin
			regulator_off <= s[0];
			hw_wake_n <= 1'b0;
			repeat (8) @(posedge pclk);
			chk({regulators_on, diag_oe}, {31'h0, ~s[0]});
			angle_is(6'h00);
			hw_wake_n <= 1'b1;
			repeat (8) @(posedge pclk);
			chk({31'h0, regulators_on}, 32'h1);
		end
		apb(1'b0, stepper_pkg::OFS_STATUS, 32'h0);
		chk(r & 32'h3FF, 32'h000);
		tally_and_finish;
	end
endmodule
`default_nettype wire

// ==== rtl/stepper_pkg.sv ====
// shared constants and types for the stepper sequencer block
package stepper_pkg;

	// ------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STEP = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	localparam logic [7:0] OFS_TABLE = 8'h0C;

	// ------------------------------------------------------------
	// control and table register fields
	// ------------------------------------------------------------
	localparam int CTRL_SLEEP = 0;
	localparam int CTRL_DIR = 1;
	localparam int CTRL_RES_LO = 2;
	localparam int CTRL_SEL_LO = 5;
	localparam int CTRL_SERIAL = 7;
	localparam int TBL_IDX_LO = 16;

	// ------------------------------------------------------------
	// fault bit positions, same in status register
	// ------------------------------------------------------------
	localparam int NFAULT = 10;
	localparam int F_OV = 0;
	localparam int F_VLOW = 1;
	localparam int F_UV = 2;
	localparam int F_CPUV = 3;
	localparam int F_TW = 4;
	localparam int F_OT = 5;
	localparam int F_SHORT = 6;
	localparam int F_OPEN = 7;
	localparam int F_STALL = 8;
	localparam int F_SER = 9;

	// ------------------------------------------------------------
	// sequencer constants and reset values
	// ------------------------------------------------------------
	localparam logic [5:0] ANGLE_HOME = 6'h08;
	localparam logic [5:0] ANGLE_HOME_FULL1 = 6'h00;
	localparam logic [5:0] GRID_FULL = 6'h10;
	localparam logic [5:0] GRID_HALF = 6'h08;
	localparam logic [5:0] GRID_QTR = 6'h04;
	localparam logic [5:0] GRID_EIGHTH = 6'h02;
	localparam logic [5:0] GRID_SIXTEENTH = 6'h01;
	localparam logic [5:0] OFFSET_FULL2 = 6'h08;

	typedef enum logic [2:0]
	{
		RES_FULL1 = 3'b000,
		RES_FULL2 = 3'b001,
		RES_HALF_U = 3'b010,
		RES_HALF_C = 3'b011,
		RES_QUARTER = 3'b100,
		RES_EIGHTH = 3'b101,
		RES_SIXTEENTH = 3'b110
	} res_t;

	typedef enum logic [1:0]
	{
		SEL_GENERAL = 2'b00,
		SEL_STALL = 2'b01,
		SEL_SUPPLY = 2'b10,
		SEL_OPEN = 2'b11
	} sel_t;

	localparam logic [2:0] RES_RESET = 3'b011;
	localparam logic [1:0] SEL_RESET = 2'b00;

endpackage

// ==== rtl/stepper_sequencer_sleep_fault_ctrl.sv ====
// stepper sequencer, sleep control and fault capture behind apb
// ------------------------------------------------------------
// Overview of operation
// - table entry: two 6-bit levels, two directions
// - angle starts at 8, full single 0
// - resolution resets to compensated half step
// - three-bit field picks step pin sequence
// - new resolution snaps to next valid angle
// - increment only if pin and bit zero
// - serial signed delta added to angle
// - angle indexes table for both phases
// - sleep when wake pin low or bit set
// - bit sleep starts after strobe rising edge
// - sleep disables outputs, indicator shows entry result
// - pin sleep exits on pin rising edge
// - strobe fall wakes, transfer must clear bit
// - fault bits sticky until clearing events
// - short, open, stall latched; others static
// - listed faults disable outputs, others flag
// - indicator defaults to general fault flag
// - four indicator sources, each low active
// - 64-entry table addressed by angle
// - step pin rising edge moves angle
// - direction pin sampled at step edge
// ------------------------------------------------------------
//
// The implementer's own choices: the register addresses and the APB register port.
`timescale 1ns/1ps
`default_nettype none

module stepper_sequencer_sleep_fault_ctrl
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic step,
	input wire logic dir,
	input wire logic hw_wake_n,
	input wire logic strobe_n,
	input wire logic regulator_off,
	input wire logic [9:0] fault_in,
	output logic [5:0] phase_a_level,
	output logic phase_a_dir,
	output logic [5:0] phase_b_level,
	output logic phase_b_dir,
	output logic outputs_enable,
	output logic regulators_on,
	output logic diag_out,
	output logic diag_oe
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	localparam int NPIN = 5;
	localparam int P_STEP = 0;
	localparam int P_DIR = 1;
	localparam int P_WAKE = 2;
	localparam int P_STRB = 3;
	localparam int P_ROFF = 4;

	typedef struct packed
	{
		logic [NPIN-1:0] pin_m;
		logic [NPIN-1:0] pin_s;
		logic [NPIN-1:0] pin_d;
		logic [9:0] flt_m;
		logic [9:0] flt_s;
		logic sleep_request_bit;
		logic dir_bit;
		logic [2:0] step_resolution_sel;
		logic [1:0] indicator_select;
		logic serial_ctrl;
		logic [5:0] tbl_idx;
		logic [63:0][13:0] tbl;
		logic [5:0] angle;
		logic [1:0] quad;
		logic stall_ind;
		logic asleep;
		logic [9:0] sts;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic [9:0] rd_clr;
		logic [5:0] a_lvl;
		logic a_dir;
		logic [5:0] b_lvl;
		logic b_dir;
		logic outen;
		logic reg_on;
		logic diag_oe;
	} state_t;

	state_t r_reg;
	state_t r_next;

	// ------------------------------------------------------------
	// next angle for a given resolution and direction
	// ------------------------------------------------------------
	function automatic logic [5:0] next_angle
	(
		input logic [5:0] a,
		input logic [2:0] res,
		input logic fwd
	);
		logic [5:0] g;
		logic [5:0] o;
		logic [5:0] rel;
		logic [5:0] base;
		g = stepper_pkg::GRID_SIXTEENTH;
		o = 6'h00;
		case (res)
			stepper_pkg::RES_FULL1: g = stepper_pkg::GRID_FULL;
			stepper_pkg::RES_FULL2:
			begin
				g = stepper_pkg::GRID_FULL;
				o = stepper_pkg::OFFSET_FULL2;
			end
			stepper_pkg::RES_HALF_U: g = stepper_pkg::GRID_HALF;
			stepper_pkg::RES_HALF_C: g = stepper_pkg::GRID_HALF;
			stepper_pkg::RES_QUARTER: g = stepper_pkg::GRID_QTR;
			stepper_pkg::RES_EIGHTH: g = stepper_pkg::GRID_EIGHTH;
			default: g = stepper_pkg::GRID_SIXTEENTH;
		endcase
		// off-grid angles snap to the nearest valid one ahead
		rel = a - o;
		base = (rel & ~(g - 6'h01)) + o;
		if (fwd)
			next_angle = base + g;
		else if ((rel & (g - 6'h01)) == 6'h00)
			next_angle = a - g;
		else
			next_angle = base;
	endfunction

	// ------------------------------------------------------------
	// combinational next state
	// ------------------------------------------------------------
	logic [NPIN-1:0] rise;
	logic [NPIN-1:0] fall;
	logic sleeping;
	logic hit;
	logic [31:0] rdata;
	logic [9:0] flt;
	logic [13:0] entry;
	logic general;
	logic supply;
	logic disable_out;
	logic fwd;

	always_comb
	begin
		r_next = r_reg;
		rise = r_reg.pin_s & ~r_reg.pin_d;
		fall = ~r_reg.pin_s & r_reg.pin_d;
		flt = r_reg.flt_s;
		hit = 1'b1;
		rdata = 32'h0000_0000;
		entry = r_reg.tbl[r_reg.angle];
		fwd = 1'b0;

		// pins pass three flops; edges come from the second and third
		r_next.pin_m = {regulator_off, strobe_n, hw_wake_n, dir, step};
		r_next.pin_s = r_reg.pin_m;
		r_next.pin_d = r_reg.pin_s;
		r_next.flt_m = fault_in;
		r_next.flt_s = r_reg.flt_m;

		// bit sleep is held off while strobe is low, so a transfer
		// wakes the part at strobe fall and sleeps again at strobe
		// rise if the bit is still set
		sleeping = ~r_reg.pin_s[P_WAKE]
			| (r_reg.sleep_request_bit & r_reg.pin_s[P_STRB]);
		r_next.asleep = sleeping;

		// ------------------------------------------------------------
		// apb slave: answer registered at setup, taken in access
		// ------------------------------------------------------------
		case (paddr)
			stepper_pkg::OFS_CTRL:
			begin
				rdata[stepper_pkg::CTRL_SLEEP] = r_reg.sleep_request_bit;
				rdata[stepper_pkg::CTRL_DIR] = r_reg.dir_bit;
				rdata[stepper_pkg::CTRL_RES_LO +: 3] =
					r_reg.step_resolution_sel;
				rdata[stepper_pkg::CTRL_SEL_LO +: 2] = r_reg.indicator_select;
				rdata[stepper_pkg::CTRL_SERIAL] = r_reg.serial_ctrl;
			end
			stepper_pkg::OFS_STEP: rdata[5:0] = r_reg.angle;
			stepper_pkg::OFS_STATUS: rdata[9:0] = r_reg.sts;
			stepper_pkg::OFS_TABLE:
			begin
				rdata[13:0] = r_reg.tbl[r_reg.tbl_idx];
				rdata[stepper_pkg::TBL_IDX_LO +: 6] = r_reg.tbl_idx;
			end
			default: hit = 1'b0;
		endcase

		r_next.rd_clr = 10'h000;
		if (psel && !penable && !r_reg.pready)
		begin
			r_next.pready = 1'b1;
			r_next.pslverr = ~hit;
			r_next.prdata = pwrite ? 32'h0000_0000 : rdata;
		end
		if (psel && penable && r_reg.pready)
		begin
			r_next.pready = 1'b0;
			r_next.pslverr = 1'b0;
			if (!pwrite && hit && paddr == stepper_pkg::OFS_STATUS)
				r_next.rd_clr = r_reg.prdata[9:0];
			if (pwrite && hit)
			begin
				case (paddr)
					stepper_pkg::OFS_CTRL:
					begin
						r_next.sleep_request_bit =
							pwdata[stepper_pkg::CTRL_SLEEP];
						r_next.dir_bit = pwdata[stepper_pkg::CTRL_DIR];
						r_next.step_resolution_sel =
							pwdata[stepper_pkg::CTRL_RES_LO +: 3];
						r_next.indicator_select =
							pwdata[stepper_pkg::CTRL_SEL_LO +: 2];
						r_next.serial_ctrl = pwdata[stepper_pkg::CTRL_SERIAL];
					end
					stepper_pkg::OFS_TABLE:
					begin
						r_next.tbl_idx = pwdata[stepper_pkg::TBL_IDX_LO +: 6];
						r_next.tbl[pwdata[stepper_pkg::TBL_IDX_LO +: 6]] =
							pwdata[13:0];
					end
					default:
					begin
					end
				endcase
			end
		end

		// ------------------------------------------------------------
		// step sequencer
		// ------------------------------------------------------------
		if (sleeping)
		begin
			if (r_reg.step_resolution_sel == stepper_pkg::RES_FULL1)
				r_next.angle = stepper_pkg::ANGLE_HOME_FULL1;
			else
				r_next.angle = stepper_pkg::ANGLE_HOME;
		end
		else if (r_reg.serial_ctrl)
		begin
			// delta wraps in six bits, so negatives subtract
			if (psel && penable && r_reg.pready && pwrite
				&& paddr == stepper_pkg::OFS_STEP)
				r_next.angle = r_reg.angle + pwdata[5:0];
		end
		else if (rise[P_STEP])
		begin
			fwd = ~r_reg.pin_s[P_DIR] & ~r_reg.dir_bit;
			r_next.angle = next_angle(r_reg.angle,
				r_reg.step_resolution_sel, fwd);
		end

		// ------------------------------------------------------------
		// fault capture
		// ------------------------------------------------------------
		// a fault present in the read-clear cycle sets the bit again
		if (sleeping || rise[P_WAKE])
			r_next.sts = 10'h000;
		else
			r_next.sts = (r_reg.sts & ~r_reg.rd_clr) | flt;

		// stall indicator only follows the fault on a quadrant change
		r_next.quad = r_reg.angle[5:4];
		if (r_reg.angle[5:4] != r_reg.quad)
			r_next.stall_ind = flt[stepper_pkg::F_STALL];
		if (sleeping)
			r_next.stall_ind = 1'b0;

		general = (|(flt & ~10'h1C0))
			| r_reg.sts[stepper_pkg::F_SHORT]
			| r_reg.sts[stepper_pkg::F_OPEN]
			| r_reg.sts[stepper_pkg::F_STALL];
		supply = flt[stepper_pkg::F_OV] | flt[stepper_pkg::F_VLOW]
			| flt[stepper_pkg::F_CPUV];
		disable_out = flt[stepper_pkg::F_OV] | flt[stepper_pkg::F_UV]
			| flt[stepper_pkg::F_CPUV] | flt[stepper_pkg::F_OT]
			| r_reg.sts[stepper_pkg::F_SHORT];

		// ------------------------------------------------------------
		// outputs
		// ------------------------------------------------------------
		r_next.a_lvl = entry[12:7];
		r_next.a_dir = entry[13];
		r_next.b_lvl = entry[5:0];
		r_next.b_dir = entry[6];
		r_next.outen = ~sleeping & ~disable_out;
		r_next.reg_on = ~sleeping;

		if (sleeping)
			r_next.diag_oe = ~r_reg.pin_s[P_ROFF];
		else
		begin
			case (r_reg.indicator_select)
				stepper_pkg::SEL_GENERAL: r_next.diag_oe = general;
				stepper_pkg::SEL_STALL: r_next.diag_oe = r_reg.stall_ind;
				stepper_pkg::SEL_SUPPLY: r_next.diag_oe = supply;
				stepper_pkg::SEL_OPEN:
					r_next.diag_oe = r_reg.sts[stepper_pkg::F_OPEN];
				default: r_next.diag_oe = general;
			endcase
		end
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			r_reg <= '0;
			r_reg.angle <= stepper_pkg::ANGLE_HOME;
			r_reg.step_resolution_sel <= stepper_pkg::RES_RESET;
			r_reg.indicator_select <= stepper_pkg::SEL_RESET;
			r_reg.pin_m <= 5'h1F;
			r_reg.pin_s <= 5'h1F;
			r_reg.pin_d <= 5'h1F;
			r_reg.pin_m[0] <= 1'b0;
			r_reg.pin_s[0] <= 1'b0;
			r_reg.pin_d[0] <= 1'b0;
		end
		else
			r_reg <= r_next;
	end

	assign prdata = r_reg.prdata;
	assign pready = r_reg.pready;
	assign pslverr = r_reg.pslverr;
	assign phase_a_level = r_reg.a_lvl;
	assign phase_a_dir = r_reg.a_dir;
	assign phase_b_level = r_reg.b_lvl;
	assign phase_b_dir = r_reg.b_dir;
	assign outputs_enable = r_reg.outen;
	assign regulators_on = r_reg.reg_on;
	assign diag_out = 1'b0;
	assign diag_oe = r_reg.diag_oe;

endmodule

`default_nettype wire
